//--- verilog/iew_top.sv
// Interrupt enable, request gating, priority and idle/power-down wake.
// Assumes core_clk is one machine cycle; core reads enable reg via SFR port.
//
// Operation
// - Six sources: two external pins, three timers, serial port, each vectored.
// - Each source gated by its own enable bit; one allows, zero blocks.
// - Bit 7 global enable zero blocks all acknowledges; one defers to bits.
// - Enable bits: 5 timer2, 4 serial, 3 timer1, 2 ext1, 1 timer0, 0 ext0.
// - Timer 2 request is OR of overflow flag and external flag.
// - Timer 2 flags never cleared on vectoring; software clears them.
// - Timer 0/1 flags set in overflow cycle, polled in the next cycle.
// - In idle, peripherals keep running and registers stay unchanged.
// - Idle ends on any enabled asserted interrupt or hardware reset.
// - Power-down ends only on reset or an enabled external pin.
`include "iew_cfg.svh"
`default_nettype none
module iew_top
   import iew_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic ext_irq_pin_0_n,
   input wire logic ext_irq_pin_1_n,
   input wire logic timer0_overflow,
   input wire logic timer1_overflow,
   input wire logic timer0_flag_clr,
   input wire logic timer1_flag_clr,
   input wire logic timer2_overflow_flag,
   input wire logic timer2_external_flag,
   input wire logic serial_irq_flag,
   input wire logic idle_enter,
   input wire logic pdown_enter,
   input wire logic irq_ack,
   output logic timer0_overflow_flag,
   output logic timer1_overflow_flag,
   output logic irq_req,
   output logic [2:0] irq_vec,
   output logic core_idle,
   output logic osc_stopped
);
   iew_state_t st;
   iew_state_t next_st;
   logic [5:0] raw;
   logic [5:0] gated;
   logic ext_wake;

   // Lowest index wins; order matches vector order
   function automatic logic [2:0] iew_pick(input logic [5:0] req);
      logic [2:0] v;
      v = `IEW_VEC_NONE;
      for (int i = `IEW_NSRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            v = 3'(i);
         end
      end
      return v;
   endfunction : iew_pick

   always_comb begin
      next_st = st;
      // Pins pass two flops before use
      next_st.x0_sync = {st.x0_sync[0], ~ext_irq_pin_0_n};
      next_st.x1_sync = {st.x1_sync[0], ~ext_irq_pin_1_n};
      if (reg_wr) begin
         next_st.enable = reg_wdata & `IEW_EN_WMASK;
      end
      // Overflow sets flag; set beats clear
      next_st.t0_flag = timer0_overflow | (st.t0_flag & ~timer0_flag_clr);
      next_st.t1_flag = timer1_overflow | (st.t1_flag & ~timer1_flag_clr);
      // Polled a cycle after setting
      next_st.t0_pend = st.t0_flag;
      next_st.t1_pend = st.t1_flag;
      // Index order gives priority
      raw[0] = st.x0_sync[1];
      raw[1] = st.t0_pend & st.t0_flag;
      raw[2] = st.x1_sync[1];
      raw[3] = st.t1_pend & st.t1_flag;
      raw[4] = serial_irq_flag;
      raw[5] = timer2_overflow_flag | timer2_external_flag;
      gated = raw & {st.enable[`IEW_EN_T2], st.enable[`IEW_EN_SER], st.enable[`IEW_EN_T1],
                     st.enable[`IEW_EN_X1], st.enable[`IEW_EN_T0],
                     st.enable[`IEW_EN_X0]};
      ext_wake = gated[0] | gated[2];
      // Ack hides the request for one cycle
      next_st.irq_req = st.enable[`IEW_EN_GLOBAL] & (|gated) & ~irq_ack;
      next_st.irq_vec = iew_pick(gated);
      // Only the external pins end power-down
      unique case (st.mode)
         IEW_RUN: begin
            if (pdown_enter) begin
               next_st.mode = IEW_PDOWN;
            end else if (idle_enter) begin
               next_st.mode = IEW_IDLE;
            end
         end
         IEW_IDLE: begin
            if (|gated) begin
               next_st.mode = IEW_RUN;
            end
         end
         IEW_PDOWN: begin
            if (ext_wake) begin
               next_st.mode = IEW_RUN;
            end
         end
         default: next_st.mode = IEW_RUN;
      endcase
      next_st.rd_data = next_st.enable;
      next_st.idle_out = (next_st.mode == IEW_IDLE);
      next_st.pdown_out = (next_st.mode == IEW_PDOWN);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st <= '{enable: `IEW_EN_RESET, mode: IEW_RUN, irq_vec: `IEW_VEC_NONE, default: '0};
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rd_data;
   assign irq_req = st.irq_req;
   assign irq_vec = st.irq_vec;
   assign core_idle = st.idle_out;
   assign osc_stopped = st.pdown_out;
   assign timer0_overflow_flag = st.t0_flag;
   assign timer1_overflow_flag = st.t1_flag;

   // Reserved bit never stored
   reserved_bit_a: assert property (@(posedge core_clk) disable iff (rst)
      reg_rdata[`IEW_EN_RSVD] == 1'b0)
      else $error("reserved enable bit set");

   // Stored enables change on writes only
   enable_write_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && reg_wr |=> reg_rdata == ($past(reg_wdata) & `IEW_EN_WMASK))
      else $error("enable write lost");
   enable_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && !reg_wr |=> $stable(reg_rdata))
      else $error("enable changed without write");

   // Global and per-source gating, and request drop on ack
   global_block_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && !st.enable[`IEW_EN_GLOBAL] |=> !irq_req)
      else $error("req with global off");
   enable_gate_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && gated == 6'h00 |=> !irq_req)
      else $error("req without enabled source");
   vec_none_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && gated == 6'h00 |=> irq_vec == `IEW_VEC_NONE)
      else $error("vector without source");
   ack_drop_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && irq_ack |=> !irq_req)
      else $error("req held through ack");

   // Timer 0 and 1 flags: set, clear, polled a cycle later
   t0_set_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && timer0_overflow |=> timer0_overflow_flag)
      else $error("t0 flag not set");
   t1_set_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && timer1_overflow |=> timer1_overflow_flag)
      else $error("t1 flag not set");
   t0_clear_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && timer0_flag_clr && !timer0_overflow |=> !timer0_overflow_flag)
      else $error("t0 flag not cleared");
   t1_clear_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && timer1_flag_clr && !timer1_overflow |=> !timer1_overflow_flag)
      else $error("t1 flag not cleared");
   t0_poll_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && timer0_overflow && st.enable[`IEW_EN_T0] && st.enable[`IEW_EN_GLOBAL]
      && !st.t0_flag && !irq_ack && !reg_wr |=> !(irq_req && irq_vec == `IEW_VEC_T0))
      else $error("t0 polled too early");
   t1_poll_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && timer1_overflow && !st.t1_flag |=> !(irq_req && irq_vec == `IEW_VEC_T1))
      else $error("t1 polled too early");
   t0_next_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && !irq_ack && st.enable[`IEW_EN_GLOBAL] && st.enable[`IEW_EN_T0]
      && st.t0_pend && st.t0_flag |=> irq_req)
      else $error("t0 poll missed");

   // Timer 2 request polled in its own cycle
   t2_same_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && !irq_ack && st.enable[`IEW_EN_GLOBAL] && st.enable[`IEW_EN_T2]
      && (timer2_overflow_flag || timer2_external_flag) |=> irq_req)
      else $error("t2 request missed");

   // Fixed service order
   prio_x0_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && gated[`IEW_VEC_X0] |=> irq_vec == `IEW_VEC_X0)
      else $error("ext0 not first");
   prio_t0_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && gated[`IEW_VEC_T0] && !gated[`IEW_VEC_X0] |=> irq_vec == `IEW_VEC_T0)
      else $error("timer0 not second");

   // Idle and power-down entry, hold and wake
   idle_entry_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && st.mode == IEW_RUN && idle_enter && !pdown_enter |=> core_idle)
      else $error("idle not entered");
   idle_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && st.mode == IEW_IDLE && gated == 6'h00 |=> core_idle)
      else $error("idle left early");
   idle_wake_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && st.mode == IEW_IDLE && |gated |=> !core_idle)
      else $error("idle not ended");
   pdown_entry_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && st.mode == IEW_RUN && pdown_enter |=> osc_stopped)
      else $error("power-down not entered");
   pdown_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && st.mode == IEW_PDOWN && !ext_wake |=> osc_stopped)
      else $error("power-down left early");
   pdown_wake_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && st.mode == IEW_PDOWN && ext_wake |=> !osc_stopped)
      else $error("power-down not ended");
   ext1_wake_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && st.mode == IEW_PDOWN && gated[`IEW_VEC_X1] |=> !osc_stopped)
      else $error("ext1 did not wake");
endmodule : iew_top
`default_nettype wire

//--- verilog/iew_cfg.svh
// Constants for the interrupt enable and wake block.
// Assumes inclusion by bare name from the design sources.
`ifndef IEW_CFG_SVH
`define IEW_CFG_SVH
`define IEW_EN_GLOBAL 7
`define IEW_EN_RSVD 6
`define IEW_EN_T2 5
`define IEW_EN_SER 4
`define IEW_EN_T1 3
`define IEW_EN_X1 2
`define IEW_EN_T0 1
`define IEW_EN_X0 0
`define IEW_EN_RESET 8'h00
`define IEW_EN_WMASK 8'hBF
`define IEW_NSRC 6
`define IEW_VEC_X0 3'h0
`define IEW_VEC_T0 3'h1
`define IEW_VEC_X1 3'h2
`define IEW_VEC_T1 3'h3
`define IEW_VEC_SER 3'h4
`define IEW_VEC_T2 3'h5
`define IEW_VEC_NONE 3'h7
`endif

//--- verilog/iew_pkg.sv
// Types for the interrupt enable and wake block.
// Assumes iew_cfg.svh holds the numeric constants.
`default_nettype none
package iew_pkg;
   typedef enum logic [2:0] {
      IEW_RUN = 3'b001,
      IEW_IDLE = 3'b010,
      IEW_PDOWN = 3'b100
   } iew_mode_t;
   typedef struct packed {
      logic [7:0] enable;
      logic t0_flag;
      logic t1_flag;
      logic t0_pend;
      logic t1_pend;
      iew_mode_t mode;
      logic [1:0] x0_sync;
      logic [1:0] x1_sync;
      logic irq_req;
      logic [2:0] irq_vec;
      logic [7:0] rd_data;
      logic idle_out;
      logic pdown_out;
   } iew_state_t;
endpackage : iew_pkg
`default_nettype wire

//--- sim/iew_core_model.sv
// Core model: acknowledges each request and latches the served vector.
// Assumes one machine cycle per core_clk edge.
`default_nettype none
module iew_core_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic irq_req,
   input wire logic [2:0] irq_vec,
   output logic irq_ack,
   output logic [2:0] last_vec
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_ack <= 1'b0;
         last_vec <= 3'h7;
      end else begin
         irq_ack <= irq_req & ~irq_ack;
         if (irq_req & ~irq_ack) last_vec <= irq_vec;
      end
   end
endmodule : iew_core_model
`default_nettype wire

//--- sim/iew_top_tb.sv
// Bench for the interrupt enable and wake block.
// Assumes the package and the core model are compiled first.
`default_nettype none
module iew_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, rst = 1, reg_wr = 0, idle_in = 0, pd_in = 0;
   logic ack, req, idle, osc_off;
   logic [7:0] wdata = 8'h00, rdata;
   logic [6:0] src = 7'h00;
   logic [1:0] ovf = 2'b00, clr = 2'b00, tflag;
   logic [2:0] vec, last_vec;
   int bad_count = 0, checks = 0, cyc_n = 0, b;
   always #20 core_clk = ~core_clk;
   iew_top iew_top_i (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .reg_wr(reg_wr),
      .reg_wdata(wdata), .reg_rdata(rdata), .ext_irq_pin_0_n(~src[0]),
      .ext_irq_pin_1_n(~src[2]), .timer0_overflow(ovf[0]), .timer1_overflow(ovf[1]),
      .timer0_flag_clr(clr[0]), .timer1_flag_clr(clr[1]), .timer2_overflow_flag(src[6]),
      .timer2_external_flag(src[5]), .serial_irq_flag(src[4]), .idle_enter(idle_in),
      .pdown_enter(pd_in), .irq_ack(ack), .timer0_overflow_flag(tflag[0]),
      .timer1_overflow_flag(tflag[1]), .irq_req(req), .irq_vec(vec), .core_idle(idle),
      .osc_stopped(osc_off));
   iew_core_model iew_core_model_i (.core_clk(core_clk), .rst(rst), .irq_req(req),
      .irq_vec(vec), .irq_ack(ack), .last_vec(last_vec));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #5;
   endtask : cyc
   task automatic wr(input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic pulse_src(input logic [6:0] lv, input logic [1:0] tov);
      @(posedge core_clk);
      src <= lv;
      ovf <= tov;
      @(posedge core_clk);
      ovf <= 2'b00;
   endtask : pulse_src
   task automatic tally_and_finish();
      if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   always @(posedge core_clk) begin
      cyc_n++;
      if (cyc_n == 2000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   initial begin
      cyc(9);
      @(posedge core_clk) rst <= 1'b0;
      cyc(1);
      chk("reset enable", rdata, 8'h00);
      chk("reset vector", {5'h00, vec}, 8'h07);
      wr(8'hBF);
      cyc(1);
      chk("enable readback", rdata, 8'hBF);
      for (int i = 0; i < 7; i++) begin
         b = (i == 6) ? 5 : i;
         wr(8'h3F);
         pulse_src(7'h01 << i & 7'h75, {i == 3, i == 1});
         cyc(5);
         chk("global gate", {7'h00, req}, 8'h00);
         wr(8'hBF & ~(8'h01 << b));
         cyc(5);
         chk("own gate", {7'h00, req}, 8'h00);
         wr(8'h80 | (8'h01 << b));
         cyc(5);
         chk("served vector", {5'h00, last_vec}, 8'(b));
         @(posedge core_clk) clr <= 2'b11;
         src <= 7'h00;
         @(posedge core_clk) clr <= 2'b00;
      end
      pulse_src(7'h7C, 2'b11);
      wr(8'hBF);
      cyc(5);
      chk("priority", {5'h00, last_vec}, 8'h01);
      chk("priority vector", {5'h00, vec}, 8'h01);
      chk("timer flags", {6'h00, tflag}, 8'h03);
      pulse_src(7'h00, 2'b00);
      wr(8'h11);
      @(posedge core_clk) idle_in <= 1'b1;
      @(posedge core_clk) idle_in <= 1'b0;
      cyc(3);
      chk("idle", {7'h00, idle}, 8'h01);
      pulse_src(7'h10, 2'b00);
      cyc(3);
      chk("idle wake", {7'h00, idle}, 8'h00);
      @(posedge core_clk) pd_in <= 1'b1;
      @(posedge core_clk) pd_in <= 1'b0;
      cyc(5);
      chk("pdown holds", {7'h00, osc_off}, 8'h01);
      pulse_src(7'h11, 2'b00);
      cyc(5);
      chk("pdown wake", {7'h00, osc_off}, 8'h00);
      pulse_src(7'h00, 2'b00);
      cyc(3);
      @(posedge core_clk) pd_in <= 1'b1;
      @(posedge core_clk) pd_in <= 1'b0;
      cyc(2);
      chk("pdown again", {7'h00, osc_off}, 8'h01);
      @(posedge core_clk) rst <= 1'b1;
      @(posedge core_clk) rst <= 1'b0;
      cyc(1);
      chk("reset wake", {7'h00, osc_off}, 8'h00);
      chk("reset clears enable", rdata, 8'h00);
      tally_and_finish();
   end
endmodule : iew_top_tb
`default_nettype wire
